// *** design/lsbr_readout.sv ***
// Line readout: syncs pixel clock and start pulse, steps through 1056 pixels,
// emits one bright/dark bit per pixel clock. Analog front end is a digital sample.
`timescale 1ns/1ps
module lsbr_readout
  import lsbr_pkg::*;
#(
  parameter int LINE_PIXELS = LSBR_LINE_PIXELS,
  parameter int SEG_PIXELS = LSBR_SEG_PIXELS
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Controller link
  input wire logic pixel_clock_in,
  input wire logic line_start_pulse_in,
  // Sensor sample of current pixel
  input wire logic [LSBR_PIX_W-1:0] pixel_in,
  // Video and status
  output logic video_bit_out,
  output logic line_active_out,
  output lsbr_pos_t pos_out
);
  logic [2:0] clk_sync;
  logic [1:0] sp_sync;
  logic clk_rise;
  logic sp_level;
  logic [LSBR_IDX_W-1:0] idx;
  logic [LSBR_IDX_W-1:0] next_idx;
  logic last_pixel;
  logic shift_step;
  logic sample_en;
  logic line_restart;
  logic bright;
  lsbr_state_t state;
  lsbr_state_t next_state;
  lsbr_pos_t next_pos;

  // Segment/offset split of a line index
  function automatic lsbr_pos_t lsbr_split(input logic [LSBR_IDX_W-1:0] i);
    lsbr_pos_t p;
    p.segment = LSBR_SEG_W'(i / LSBR_IDX_W'(SEG_PIXELS));
    p.offset = LSBR_OFS_W'(i % LSBR_IDX_W'(SEG_PIXELS));
    return p;
  endfunction : lsbr_split

  // Two-flop sync plus one history stage for edge finding
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clk_sync <= 3'h0;
      sp_sync <= 2'h0;
    end else if (clk_en_in) begin
      clk_sync <= {clk_sync[1:0], pixel_clock_in};
      sp_sync <= {sp_sync[0], line_start_pulse_in};
    end
  end

  // Edge and step decode
  assign clk_rise = clk_sync[1] && !clk_sync[2];
  assign sp_level = sp_sync[1];
  assign line_restart = clk_rise && sp_level;
  assign shift_step = clk_rise && !sp_level && (state == LSBR_SHIFT);
  assign sample_en = clk_rise && (state == LSBR_SHIFT);
  assign last_pixel = idx == LSBR_IDX_W'(LINE_PIXELS - 1);
  assign next_idx = line_restart ? LSBR_IDX_RESET
                  : (shift_step && !last_pixel) ? idx + 11'h001 : idx;
  assign next_pos = lsbr_split(next_idx);

  // Line state decode
  always_comb begin
    next_state = state;
    case (state)
      LSBR_IDLE: if (line_restart) next_state = LSBR_SHIFT;
      LSBR_SHIFT: begin
        if (line_restart) next_state = LSBR_SHIFT;
        else if (shift_step && last_pixel) next_state = LSBR_DONE;
      end
      LSBR_DONE: if (line_restart) next_state = LSBR_SHIFT;
      default: next_state = LSBR_IDLE;
    endcase
  end

  // Index, state and registered outputs
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= LSBR_IDLE;
      idx <= LSBR_IDX_RESET;
      pos_out <= '0;
      line_active_out <= 1'b0;
    end else if (clk_en_in) begin
      state <= next_state;
      idx <= next_idx;
      pos_out <= next_pos;
      line_active_out <= next_state == LSBR_SHIFT;
    end
  end

  // Pixel decision; sample on each pixel clock of an active line
  lsbr_tracker u_tracker (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .sample_en_in(sample_en),
    .line_restart_in(line_restart),
    .pixel_in(pixel_in),
    .bright_out(bright)
  );

  // Video bit: 1 white, 0 dark, 0 outside a line
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      video_bit_out <= 1'b0;
    end else if (clk_en_in) begin
      video_bit_out <= bright && line_active_out;
    end
  end

  sequence s_start;
    clk_en_in && line_restart;
  endsequence
  property p_start_clears;
    @(posedge mclk_in) disable iff (!reset_n_in)
      s_start |=> (idx == LSBR_IDX_RESET) && (state == LSBR_SHIFT);
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start pulse did not restart line");

  property p_step_one;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (clk_en_in && shift_step && !last_pixel) |=> (idx == $past(idx) + 11'h001);
  endproperty
  a_step_one: assert property (p_step_one) else $error("index did not advance by one");

  property p_hold_no_edge;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (clk_en_in && !clk_rise) |=> (idx == $past(idx));
  endproperty
  a_hold_no_edge: assert property (p_hold_no_edge) else $error("index moved without clock edge");

  property p_end_line;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (clk_en_in && shift_step && last_pixel) |=> (state == LSBR_DONE) ##1 !line_active_out;
  endproperty
  a_end_line: assert property (p_end_line) else $error("line did not end at last pixel");

  property p_idx_bound;
    @(posedge mclk_in) disable iff (!reset_n_in)
      idx < LSBR_IDX_W'(LINE_PIXELS);
  endproperty
  a_idx_bound: assert property (p_idx_bound) else $error("index beyond line length");

  property p_pos_split;
    @(posedge mclk_in) disable iff (!reset_n_in)
      clk_en_in |=> (pos_out.segment < LSBR_SEG_W'(LSBR_SEGMENTS)) && (pos_out.offset < LSBR_OFS_W'(SEG_PIXELS));
  endproperty
  a_pos_split: assert property (p_pos_split) else $error("segment position out of range");

  property p_video_idle;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (clk_en_in && !line_active_out) |=> !video_bit_out;
  endproperty
  a_video_idle: assert property (p_video_idle) else $error("video high outside a line");

  property p_video_follow;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (clk_en_in && line_active_out) |=> (video_bit_out == $past(bright));
  endproperty
  a_video_follow: assert property (p_video_follow) else $error("video bit not the decision");

  // Status flag mirrors the line state
  property p_active_state;
    @(posedge mclk_in) disable iff (!reset_n_in)
      line_active_out == (state == LSBR_SHIFT);
  endproperty
  a_active_state: assert property (p_active_state) else $error("line flag disagrees with state");

  // Segment and offset always rebuild the line index
  property p_pos_sum;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (int'(pos_out.segment) * SEG_PIXELS + int'(pos_out.offset)) == int'(idx);
  endproperty
  a_pos_sum: assert property (p_pos_sum) else $error("position does not match index");

  // Offset wraps into the next segment of the chain
  sequence s_step;
    clk_en_in && shift_step && !last_pixel;
  endsequence
  property p_seg_carry;
    @(posedge mclk_in) disable iff (!reset_n_in)
      s_step ##0 (pos_out.offset == LSBR_OFS_W'(SEG_PIXELS - 1))
        |=> (pos_out.offset == 7'h00) && (pos_out.segment == $past(pos_out.segment) + 4'h1);
  endproperty
  a_seg_carry: assert property (p_seg_carry) else $error("segment did not carry");

  // Rises outside a line are refused
  property p_idle_refuse;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (clk_en_in && (state != LSBR_SHIFT) && !line_restart) |=> !line_active_out && (idx == $past(idx));
  endproperty
  a_idle_refuse: assert property (p_idle_refuse) else $error("rise outside a line was taken");

  // Finished line waits at its last pixel
  property p_done_holds;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (clk_en_in && (state == LSBR_DONE) && !line_restart) |=> (state == LSBR_DONE) && last_pixel;
  endproperty
  a_done_holds: assert property (p_done_holds) else $error("finished line left its end");

  // Low enable freezes readout and video
  property p_freeze;
    @(posedge mclk_in) disable iff (!reset_n_in)
      !clk_en_in |=> $stable(idx) && $stable(state) && $stable(video_bit_out) && $stable(pos_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");

  // First pixel of a line at position zero
  property p_first_out;
    @(posedge mclk_in) disable iff (!reset_n_in)
      s_start |=> line_active_out && (pos_out == '0);
  endproperty
  a_first_out: assert property (p_first_out) else $error("line did not open at pixel zero");

  // First video bit is the decision on pixel zero
  sequence s_first_pixel;
    s_start ##1 clk_en_in;
  endsequence
  property p_first_video;
    @(posedge mclk_in) disable iff (!reset_n_in)
      s_first_pixel |=> (video_bit_out == $past(bright));
  endproperty
  a_first_video: assert property (p_first_video) else $error("first video bit wrong");
endmodule : lsbr_readout

// *** design/lsbr_tracker.sv ***
// Background tracker and comparator for one pixel per enable.
// Assumes pixel samples are stable on the cycle sample_en_in is high.
`timescale 1ns/1ps
module lsbr_tracker
  import lsbr_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Pixel sample
  input wire logic sample_en_in,
  input wire logic line_restart_in,
  input wire logic [LSBR_PIX_W-1:0] pixel_in,
  // Decision
  output logic bright_out
);
  logic [LSBR_PIX_W-1:0] bg;
  logic [LSBR_PIX_W-1:0] next_bg;
  logic [LSBR_PIX_W:0] diff_up;
  logic [LSBR_PIX_W:0] diff_dn;
  logic is_bright;
  logic take;

  // Compare raw pixel against tracked background
  assign is_bright = pixel_in > bg;
  // A line's first pixel is taken on its restart rise
  assign take = sample_en_in || line_restart_in;
  assign diff_up = {1'b0, pixel_in} - {1'b0, bg};
  assign diff_dn = {1'b0, bg} - {1'b0, pixel_in};
  assign next_bg = is_bright ? bg + LSBR_PIX_W'(diff_up >> LSBR_TRACK_SHIFT)
                             : bg - LSBR_PIX_W'(diff_dn >> LSBR_TRACK_SHIFT);

  // Leaky background average from the same stream
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bg <= LSBR_BG_RESET;
      bright_out <= 1'b0;
    end else if (clk_en_in && take) begin
      bg <= next_bg;
      bright_out <= is_bright;
    end
  end

  property p_bright_cmp;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (clk_en_in && take) |=> (bright_out == $past(is_bright));
  endproperty
  a_bright_cmp: assert property (p_bright_cmp) else $error("bit does not follow comparison");

  property p_bg_moves_up;
    @(posedge mclk_in) disable iff (!reset_n_in)
      (clk_en_in && take && is_bright && diff_up >= 9'h008) |=> (bg > $past(bg));
  endproperty
  a_bg_moves_up: assert property (p_bg_moves_up) else $error("background not tracking upward");
endmodule : lsbr_tracker

// *** shared/lsbr_pkg.sv ***
// Package for the bilevel line-scan readout: geometry, timing and carrier types.
// Assumes a 40 MHz system clock sampling the controller's pixel clock and start pulse.
// Contract
// - A line holds 1056 pixels from 11 chained segments of 96, read out in fixed order.
// - The controller supplies a running pixel clock and the readout advances on it.
// - Each pixel is compared with a background level tracked from the same stream, 1 if brighter, 0 if darker.
// - The single video bit shows 0 for dark and 1 for white.
// - A line lasts pixel count times clock period, one pixel per pixel clock.
package lsbr_pkg;
  localparam int LSBR_SEGMENTS = 11;
  localparam int LSBR_SEG_PIXELS = 96;
  localparam int LSBR_LINE_PIXELS = LSBR_SEGMENTS * LSBR_SEG_PIXELS;
  localparam int LSBR_PIX_W = 8;
  localparam int LSBR_IDX_W = 11;
  localparam int LSBR_SEG_W = 4;
  localparam int LSBR_OFS_W = 7;
  // Background tracker: shift of the leaky average
  localparam int LSBR_TRACK_SHIFT = 3;
  localparam logic [LSBR_PIX_W-1:0] LSBR_BG_RESET = 8'h80;
  localparam logic [LSBR_IDX_W-1:0] LSBR_IDX_RESET = 11'h000;
  // Pixel clock period used for line time, in ns
  localparam int LSBR_PIXCLK_NS = 500;
  localparam int LSBR_MCLK_NS = 25;
  localparam int LSBR_LINE_NS = LSBR_LINE_PIXELS * LSBR_PIXCLK_NS;

  // Readout position within a line
  typedef struct packed {
    logic [LSBR_SEG_W-1:0] segment;
    logic [LSBR_OFS_W-1:0] offset;
  } lsbr_pos_t;

  typedef enum logic [1:0] {
    LSBR_IDLE = 2'b00,
    LSBR_SHIFT = 2'b01,
    LSBR_DONE = 2'b11
  } lsbr_state_t;
endpackage : lsbr_pkg

// *** sim/lsbr_ctrl_model.sv ***
// Scanner controller stand-in: pixel clock, start pulse and sensor pixel value.
// Assumes a 25 ns bench clock; a pixel period is 4 low and 4 high bench cycles.
`timescale 1ns/1ps
module lsbr_ctrl_model
  import lsbr_pkg::*;
(
  // Bench clock
  input wire logic mclk_in,
  // Controller link and pixel
  output logic pixel_clock_out,
  output logic line_start_pulse_out,
  output logic [LSBR_PIX_W-1:0] pixel_out
);
  // Idle: pixel clock stands still low
  initial begin
    pixel_clock_out = 1'b0;
    line_start_pulse_out = 1'b0;
    pixel_out = 8'h00;
  end
  // One period, entered just after a bench edge; start and pixel held across the rise
  task automatic step(input logic start, input logic [LSBR_PIX_W-1:0] pix);
    line_start_pulse_out = start;
    pixel_out = pix;
    repeat (4) @(posedge mclk_in);
    #1 pixel_clock_out = 1'b1;
    repeat (4) @(posedge mclk_in);
    #1 pixel_clock_out = 1'b0;
  endtask : step
  // Sensor released outside a line: pixel shows the inverse
  task automatic park();
    line_start_pulse_out = 1'b0;
    pixel_out = ~pixel_out;
  endtask : park
endmodule : lsbr_ctrl_model

// *** sim/tb_lsbr_readout.sv ***
// Bench for the bilevel line readout: reset, idle clocks, a full line, a restart, a frozen enable.
// Assumes the controller model supplies pixel clock, start pulse and pixel.
`timescale 1ns/1ps
module tb_lsbr_readout;
  import lsbr_pkg::*;
  logic mclk_in, reset_n_in, clk_en_in, pclk, start, video, active;
  logic [LSBR_PIX_W-1:0] pix;
  lsbr_pos_t pos;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  lsbr_readout uut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .pixel_clock_in(pclk),
    .line_start_pulse_in(start), .pixel_in(pix), .video_bit_out(video), .line_active_out(active), .pos_out(pos));
  lsbr_ctrl_model ctrl (.mclk_in(mclk_in), .pixel_clock_out(pclk), .line_start_pulse_out(start), .pixel_out(pix));
  // Bench clock
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  // Hang guard
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Every third pixel white, the rest black
  function automatic logic [LSBR_PIX_W-1:0] pix_of(input int i);
    return (i % 3 == 0) ? 8'hFF : 8'h00;
  endfunction : pix_of
  // Judge pixel i three bench cycles into the next pixel period
  task automatic see_pixel(input int i);
    repeat (3) @(posedge mclk_in);
    #2;
    check(video, (i % 3 == 0));
    check(pos, {5'h00, 4'(i / LSBR_SEG_PIXELS), 7'(i % LSBR_SEG_PIXELS)});
    check(active, 1'b1);
  endtask : see_pixel
  task automatic t_reset();
    #2;
    check({video, active, pos}, 16'h0000);
  endtask : t_reset
  // Pixel clocks with start low while idle are ignored
  task automatic t_ignore();
    repeat (3) ctrl.step(1'b0, 8'hFF);
    repeat (4) @(posedge mclk_in);
    #1;
    check({video, active, pos}, 16'h0000);
  endtask : t_ignore
  // Full line: start rise, 1056 bits, a closing rise, then line done with active and video low
  task automatic t_line();
    for (int i = 0; i <= LSBR_LINE_PIXELS; i++) begin
      fork
        ctrl.step(i == 0, pix_of(i));
        if (i > 0) see_pixel(i - 1);
      join
    end
    ctrl.park();
    repeat (4) @(posedge mclk_in);
    #1;
    check({video, active}, 16'h0000);
  endtask : t_line
  // Start during a line restarts at pixel 0
  task automatic t_restart();
    for (int i = 0; i <= 100; i++) ctrl.step(i == 0 || i == 100, pix_of(i == 100 ? 0 : i));
    repeat (3) @(posedge mclk_in);
    #2;
    check({video, active, pos}, 16'h1800);
  endtask : t_restart
  // Low enable hides a pixel clock rise; the next rise steps once
  task automatic t_freeze();
    @(posedge mclk_in) #1 clk_en_in = 1'b0;
    ctrl.step(1'b0, 8'h00);
    clk_en_in = 1'b1;
    check({video, active, pos}, 16'h1800);
    ctrl.step(1'b0, 8'h00);
    repeat (3) @(posedge mclk_in);
    #2;
    check({video, active, pos}, 16'h0801);
  endtask : t_freeze
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    reset_n_in = 1'b0;
    clk_en_in = 1'b1;
    repeat (3) @(posedge mclk_in);
    #1 reset_n_in = 1'b1;
    t_reset();
    @(posedge mclk_in) #1;
    t_ignore();
    @(posedge mclk_in) #1;
    t_line();
    @(posedge mclk_in) #1;
    t_restart();
    t_freeze();
    finish_test();
  end
endmodule : tb_lsbr_readout
